// ==== sss_core.sv ====
// startup, command window and measurement cycle sequencer
//
// Overview of operation
// (R1) temperature result scaled by two to resolution
// (R2) capacitor sizes are trim times 1.44 pF
// (R3) two-region sensor plus second-order temperature correction
// (R4) optional single-region third-order sensor correction
// (R5) four output types in either measurement mode
// (R6) all timing counted on one clock
// (R7) sequence starts when reset releases
// (R8) device answers as two-wire slave after reset
// (R9) command window 3 ms short, else 10 ms
// (R10) calibration command enters and holds command mode
// (R11) timeout or resume switches to configured output
// (R12) one full measurement cycle after leaving startup
// (R13) first result stored after capacitance correction
// (R14) then follow periodic or sleep measurement mode
// (R15) software keeps factory trims unless range changes
// (R16) wakeup, temperature, then capacitance conversion each
// (R17) power down 0, 5, 25 or 125 ms
// (R18) sleep mode waits for measurement command
// (R19) window counted in cycles from reset release
// (R20) output register holds reset value until first
`timescale 1ns/1ps
module sss_core
    import sss_pkg::*;
#(
    parameter int unsigned WIN_SHORT = WIN_SHORT_CYC,
    parameter int unsigned WIN_LONG = WIN_LONG_CYC,
    parameter int unsigned PD1 = PD_RATE1_CYC,
    parameter int unsigned PD2 = PD_RATE2_CYC,
    parameter int unsigned PD3 = PD_RATE3_CYC,
    parameter int unsigned CONV8 = CONV8_CYC,
    parameter int unsigned CONV10 = CONV10_CYC,
    parameter int unsigned CONV12 = CONV12_CYC,
    parameter int unsigned CONV14 = CONV14_CYC
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic enter_calibration_cmd,
    input wire logic resume_normal_cmd,
    input wire logic measure_cmd,
    input wire logic short_window_cfg,
    input wire logic sleep_mode_cfg,
    input wire logic [1:0] update_rate,
    input wire logic [1:0] out_proto_cfg,
    input wire logic [1:0] conversion_resolution,
    input wire logic third_order_cfg,
    input wire logic [TRIM_W-1:0] temp_trim,
    input wire logic [TRIM_W-1:0] converter_zero_trim,
    input wire logic [TRIM_W-1:0] converter_reference_trim,
    input wire logic [DATA_W-1:0] absolute_temperature_voltage,
    input wire logic [DATA_W-1:0] raw_cap_ratio,
    input wire logic [DATA_W-1:0] sensor_break,
    input wire logic signed [COEF_W-1:0] sensor_coef_lo,
    input wire logic signed [COEF_W-1:0] sensor_coef_hi,
    input wire logic signed [COEF_W-1:0] temp_coef,
    output sss_phase_t phase_q,
    output logic [1:0] active_proto_q,
    output logic [DATA_W-1:0] result_q,
    output logic result_valid_q,
    output logic [DATA_W-1:0] temp_result_q,
    output logic [CAP_W-1:0] temp_cap_ff_q,
    output logic [CAP_W-1:0] zero_cap_ff_q,
    output logic [CAP_W-1:0] ref_cap_ff_q,
    output logic third_order_q
);

    // ======================================================================
    // state
    // ======================================================================
    typedef struct packed {
        sss_phase_t phase; // sequencer phase
        logic [1:0] proto; // active output protocol
        logic [DATA_W-1:0] raw; // last scaled conversion
        logic [DATA_W-1:0] temp; // corrected temperature
        logic [DATA_W-1:0] result; // output register
        logic valid; // first result stored
        logic [CAP_W-1:0] ct; // temperature capacitor
        logic [CAP_W-1:0] cz; // zero-shift capacitor
        logic [CAP_W-1:0] cr; // reference capacitor
        logic third; // third-order mode in force
    } sss_core_st_t;

    sss_core_st_t q; // registered state
    sss_core_st_t d; // next state
    sss_tmr_if #(.TW(TMR_W)) tmr (); // phase timer link

    // ======================================================================
    // arithmetic helpers
    // ======================================================================

    // result bits for a resolution code: 8, 10, 12 or 14
    function automatic int res_bits(input logic [1:0] code);
        res_bits = int'(RES_BASE) + int'(RES_STEP) * int'(code);
    endfunction : res_bits

    // scale a full-scale ratio by two to the resolution
    function automatic logic [DATA_W-1:0] scale(
        input logic [DATA_W-1:0] ratio,
        input logic [1:0] code
    );
        scale = ratio >> (int'(DATA_W) - res_bits(code));
    endfunction : scale

    // clamp a signed value into the result range
    function automatic logic [DATA_W-1:0] clamp(
        input logic signed [63:0] v,
        input logic [1:0] code
    );
        logic signed [63:0] top;
        top = (64'sd1 <<< res_bits(code)) - 64'sd1;
        if (v < 64'sd0)
            clamp = '0;
        else if (v > top)
            clamp = DATA_W'(top);
        else
            clamp = DATA_W'(v);
    endfunction : clamp

    // second-order temperature correction
    function automatic logic [DATA_W-1:0] temp_fix(
        input logic [DATA_W-1:0] t,
        input logic [1:0] code
    );
        logic signed [63:0] ts;
        logic signed [63:0] sq;
        ts = $signed({50'h0, t});
        sq = (ts * ts) >>> res_bits(code);
        temp_fix = clamp(ts + ((64'(temp_coef) * sq) >>> COEF_FRAC), code);
    endfunction : temp_fix

    // sensor correction, two regions or one third-order region
    function automatic logic [DATA_W-1:0] sens_fix(
        input logic [DATA_W-1:0] z,
        input logic [1:0] code,
        input logic third
    );
        logic signed [63:0] zs;
        logic signed [63:0] cube;
        zs = $signed({50'h0, z});
        cube = (zs * zs * zs) >>> (2 * res_bits(code));
        if (third)
            sens_fix = clamp(zs + ((64'(sensor_coef_lo) * cube)
                             >>> COEF_FRAC), code);
        else if (z < sensor_break)
            sens_fix = clamp(zs + 64'(sensor_coef_lo), code);
        else
            sens_fix = clamp(zs + 64'(sensor_coef_hi), code);
    endfunction : sens_fix

    // conversion length for a resolution code
    function automatic logic [TMR_W-1:0] conv_len(input logic [1:0] code);
        unique case (code)
            2'h0: conv_len = TMR_W'(CONV8);
            2'h1: conv_len = TMR_W'(CONV10);
            2'h2: conv_len = TMR_W'(CONV12);
            2'h3: conv_len = TMR_W'(CONV14);
        endcase
    endfunction : conv_len

    // power-down length for an update rate code
    function automatic logic [TMR_W-1:0] pd_len(input logic [1:0] code);
        if (code == RATE_1)
            pd_len = TMR_W'(PD1);
        else if (code == RATE_2)
            pd_len = TMR_W'(PD2);
        else
            pd_len = TMR_W'(PD3);
    endfunction : pd_len

    // ======================================================================
    // sequencer
    // ======================================================================

    // next state and timer commands; everything frozen while clk_en is low
    always_comb
    begin
        d = q;
        tmr.load = 1'b0;
        tmr.value = '0;
        tmr.en = clk_en; // R6
        if (clk_en)
        begin
            // capacitor sizes follow the trim codes
            d.ct = CAP_W'(STEP_FF * temp_trim); // R2
            d.cz = CAP_W'(STEP_FF * converter_zero_trim); // R2
            d.cr = CAP_W'(STEP_FF * converter_reference_trim); // R2
            unique case (q.phase)
                // first cycle after release: start the window count
                PH_BOOT:
                begin
                    tmr.load = 1'b1; // R7 R19
                    tmr.value = short_window_cfg ? TMR_W'(WIN_SHORT)
                                                 : TMR_W'(WIN_LONG); // R9
                    d.phase = PH_WINDOW;
                end
                // window open, answering as two-wire slave
                PH_WINDOW:
                begin
                    if (enter_calibration_cmd)
                    begin
                        d.phase = PH_CMD; // R10
                    end
                    else if (tmr.done)
                    begin
                        d.phase = PH_WAKE; // R11 R12
                        d.proto = out_proto_cfg; // R5
                        tmr.load = 1'b1;
                        tmr.value = TMR_W'(WAKE_CYC);
                    end
                end
                // calibration: stays here until resumed
                PH_CMD:
                begin
                    if (resume_normal_cmd)
                    begin
                        d.phase = PH_WAKE; // R11 R12
                        d.proto = out_proto_cfg; // R5
                        tmr.load = 1'b1;
                        tmr.value = TMR_W'(WAKE_CYC);
                    end
                end
                // wakeup then temperature conversion
                PH_WAKE:
                begin
                    if (tmr.done)
                    begin
                        d.phase = PH_TCONV; // R16
                        tmr.load = 1'b1;
                        tmr.value = conv_len(conversion_resolution);
                    end
                end
                // temperature conversion: capture scaled value at the end
                PH_TCONV:
                begin
                    if (tmr.done)
                    begin
                        d.raw = scale(absolute_temperature_voltage,
                                      conversion_resolution); // R1
                        d.phase = PH_TDSP; // R16
                        tmr.load = 1'b1;
                        tmr.value = TMR_W'(DSP_CYC);
                    end
                end
                // temperature correction calculation
                PH_TDSP:
                begin
                    if (tmr.done)
                    begin
                        d.temp = temp_fix(q.raw, conversion_resolution); // R3
                        d.phase = PH_CCONV; // R16
                        tmr.load = 1'b1;
                        tmr.value = conv_len(conversion_resolution);
                    end
                end
                // capacitance conversion
                PH_CCONV:
                begin
                    if (tmr.done)
                    begin
                        d.raw = scale(raw_cap_ratio, conversion_resolution);
                        d.third = third_order_cfg; // R4
                        d.phase = PH_CDSP; // R16
                        tmr.load = 1'b1;
                        tmr.value = TMR_W'(DSP_CYC);
                    end
                end
                // capacitance correction, then load the output register
                PH_CDSP:
                begin
                    if (tmr.done)
                    begin
                        d.result = sens_fix(q.raw, conversion_resolution,
                                            q.third); // R3 R4 R13
                        d.valid = 1'b1; // R13 R20
                        if (sleep_mode_cfg)
                        begin
                            d.phase = PH_SLEEP; // R14 R18
                        end
                        else if (update_rate == RATE_NONE)
                        begin
                            d.phase = PH_WAKE; // R14 R17
                            tmr.load = 1'b1;
                            tmr.value = TMR_W'(WAKE_CYC);
                        end
                        else
                        begin
                            d.phase = PH_PDOWN; // R14 R17
                            tmr.load = 1'b1;
                            tmr.value = pd_len(update_rate); // R17
                        end
                    end
                end
                // periodic mode power down
                PH_PDOWN:
                begin
                    if (tmr.done)
                    begin
                        d.phase = PH_WAKE; // R17
                        tmr.load = 1'b1;
                        tmr.value = TMR_W'(WAKE_CYC);
                    end
                end
                // sleep mode: idle until the master asks
                PH_SLEEP:
                begin
                    if (measure_cmd)
                    begin
                        d.phase = PH_WAKE; // R18
                        tmr.load = 1'b1;
                        tmr.value = TMR_W'(WAKE_CYC);
                    end
                end
                default:
                begin
                    d.phase = PH_BOOT;
                end
            endcase
        end
    end

    // register the state; output register starts at its reset value
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q <= '{phase: PH_BOOT, proto: PROTO_I2C, raw: '0, temp: '0,
                   result: RESULT_RST, valid: 1'b0, ct: '0, cz: '0,
                   cr: '0, third: 1'b0}; // R8 R20
        end
        else
        begin
            q <= d;
        end
    end

    // phase timer
    sss_timer #(.TW(TMR_W)) u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .bus(tmr.tmr)
    );

    // ======================================================================
    // outputs, straight from the state register
    // ======================================================================
    assign phase_q = q.phase;
    assign active_proto_q = q.proto;
    assign result_q = q.result;
    assign result_valid_q = q.valid;
    assign temp_result_q = q.temp;
    assign temp_cap_ff_q = q.ct;
    assign zero_cap_ff_q = q.cz;
    assign ref_cap_ff_q = q.cr;
    assign third_order_q = q.third;

    // ======================================================================
    // checks
    // ======================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_expire;
        q.phase == PH_WINDOW && clk_en && !enter_calibration_cmd
            && tmr.done;
    endsequence

    sequence s_wake_end;
        q.phase == PH_WAKE && clk_en && tmr.done;
    endsequence

    win_enter_a: assert property ( // R10
        q.phase == PH_WINDOW && clk_en && enter_calibration_cmd
        |=> phase_q == PH_CMD)
        else $error("calibration command did not enter command mode");
    cmd_stay_a: assert property ( // R10
        q.phase == PH_CMD && !(clk_en && resume_normal_cmd)
        |=> phase_q == PH_CMD)
        else $error("command mode left without resume");
    window_exit_a: assert property ( // R11
        s_expire |=> phase_q == PH_WAKE
        && active_proto_q == $past(out_proto_cfg))
        else $error("window timeout did not start measuring");
    proto_boot_a: assert property ( // R8
        phase_q inside {PH_BOOT, PH_WINDOW, PH_CMD}
        |-> active_proto_q == PROTO_I2C)
        else $error("not a two-wire slave during startup");
    first_res_a: assert property ( // R13
        $rose(result_valid_q) |-> $past(phase_q) == PH_CDSP)
        else $error("first result not stored after correction");
    reset_res_a: assert property ( // R20
        !result_valid_q |-> result_q == RESULT_RST)
        else $error("output register changed before first result");
    cycle_order_a: assert property ( // R16
        s_wake_end |=> phase_q == PH_TCONV ##0 !result_valid_q
        || phase_q == PH_TCONV)
        else $error("wakeup not followed by temperature conversion");
    rate_none_a: assert property ( // R17
        q.phase == PH_CDSP && clk_en && tmr.done && !sleep_mode_cfg
        && update_rate == RATE_NONE |=> phase_q == PH_WAKE)
        else $error("no-power-down rate did not restart");
    sleep_hold_a: assert property ( // R18
        q.phase == PH_SLEEP && !(clk_en && measure_cmd)
        |=> phase_q == PH_SLEEP)
        else $error("sleep mode measured without command");
    zero_cap_a: assert property ( // R2
        !sys_rst && clk_en |=> zero_cap_ff_q
        == CAP_W'(STEP_FF * $past(converter_zero_trim)))
        else $error("zero-shift capacitor size wrong");

endmodule : sss_core

// ==== sss_pkg.sv ====
// shared constants and types of the sensor startup sequencer
package sss_pkg;

    // ======================================================================
    // clock and time base
    // ======================================================================
    localparam int unsigned CLK_HZ = 20_000_000; // core clock rate
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000; // cycles per us
    localparam int unsigned TMR_W = 22; // width of the phase timer

    // ======================================================================
    // phase durations in microseconds and in cycles
    // ======================================================================
    localparam int unsigned WIN_SHORT_US = 3000; // short command window
    localparam int unsigned WIN_LONG_US = 10000; // default command window
    localparam int unsigned PD_RATE1_US = 5000; // power down, rate code 01
    localparam int unsigned PD_RATE2_US = 25000; // power down, rate code 10
    localparam int unsigned PD_RATE3_US = 125000; // power down, rate code 11
    localparam int unsigned CONV8_US = 300; // conversion at 8 bits
    localparam int unsigned CONV10_US = 1150; // conversion at 10 bits
    localparam int unsigned CONV12_US = 4500; // conversion at 12 bits
    localparam int unsigned CONV14_US = 18000; // conversion at 14 bits
    localparam int unsigned WAKE_US = 100; // wakeup before a cycle
    localparam int unsigned DSP_US = 100; // one correction calculation
    localparam int unsigned WIN_SHORT_CYC = WIN_SHORT_US * CYC_PER_US;
    localparam int unsigned WIN_LONG_CYC = WIN_LONG_US * CYC_PER_US;
    localparam int unsigned PD_RATE1_CYC = PD_RATE1_US * CYC_PER_US;
    localparam int unsigned PD_RATE2_CYC = PD_RATE2_US * CYC_PER_US;
    localparam int unsigned PD_RATE3_CYC = PD_RATE3_US * CYC_PER_US;
    localparam int unsigned CONV8_CYC = CONV8_US * CYC_PER_US;
    localparam int unsigned CONV10_CYC = CONV10_US * CYC_PER_US;
    localparam int unsigned CONV12_CYC = CONV12_US * CYC_PER_US;
    localparam int unsigned CONV14_CYC = CONV14_US * CYC_PER_US;
    localparam int unsigned WAKE_CYC = WAKE_US * CYC_PER_US;
    localparam int unsigned DSP_CYC = DSP_US * CYC_PER_US;

    // ======================================================================
    // data, trim and resolution layout
    // ======================================================================
    localparam int unsigned DATA_W = 14; // full-scale raw ratio width
    localparam int unsigned TRIM_W = 3; // trim code width
    localparam int unsigned CAP_W = 14; // capacitor size in fF
    localparam int unsigned STEP_FF = 1440; // trim step, 1.44 pF in fF
    localparam int unsigned RES_BASE = 8; // bits at resolution code 00
    localparam int unsigned RES_STEP = 2; // bits added per code step
    localparam int unsigned COEF_W = 16; // signed coefficient width
    localparam int unsigned COEF_FRAC = 15; // coefficient fraction bits
    localparam logic [DATA_W-1:0] RESULT_RST = 14'h0000; // before 1st result

    // ======================================================================
    // output protocol and update rate codes
    // ======================================================================
    localparam logic [1:0] PROTO_I2C = 2'h0; // two-wire slave
    localparam logic [1:0] PROTO_SPI = 2'h1; // serial peripheral
    localparam logic [1:0] PROTO_PDM = 2'h2; // pulse-density outputs
    localparam logic [1:0] PROTO_ALARM = 2'h3; // alarm switches
    localparam logic [1:0] RATE_NONE = 2'h0; // no power down
    localparam logic [1:0] RATE_1 = 2'h1; // shortest power down
    localparam logic [1:0] RATE_2 = 2'h2; // middle power down

    // sequencer phases
    typedef enum logic [3:0] {
        PH_BOOT,
        PH_WINDOW,
        PH_CMD,
        PH_WAKE,
        PH_TCONV,
        PH_TDSP,
        PH_CCONV,
        PH_CDSP,
        PH_PDOWN,
        PH_SLEEP
    } sss_phase_t;

endpackage : sss_pkg

// ==== sss_tmr_if.sv ====
// carrier between the sequencer and its phase timer
`timescale 1ns/1ps
interface sss_tmr_if #(parameter int unsigned TW = 22);
    logic load; // start a new count
    logic [TW-1:0] value; // cycles to count
    logic en; // count enable
    logic done; // count has run out

    modport ctrl (output load, output value, output en, input done);
    modport tmr (input load, input value, input en, output done);
endinterface : sss_tmr_if

// ==== sss_timer.sv ====
// down-counting phase timer in oscillator cycles
`timescale 1ns/1ps
module sss_timer
    import sss_pkg::*;
#(
    parameter int unsigned TW = 22
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    sss_tmr_if.tmr bus
);

    // ======================================================================
    // state
    // ======================================================================
    typedef struct packed {
        logic [TW-1:0] cnt; // cycles still to run
    } sss_tmr_st_t;

    sss_tmr_st_t q; // registered state
    sss_tmr_st_t d; // next state

    // load wins over counting; holds at zero
    always_comb
    begin
        d = q;
        if (bus.load)
        begin
            d.cnt = bus.value;
        end
        else if (bus.en && q.cnt != '0)
        begin
            d.cnt = q.cnt - TW'(1);
        end
    end

    // register the state
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // expiry is seen once the count reaches zero
    assign bus.done = (q.cnt == '0);

endmodule : sss_timer

// ==== sss_master_model.sv ====
// two-wire master model issuing command pulses
`timescale 1ns/1ps
module sss_master_model
(
    input wire logic sys_clk,
    output logic enter_calibration_cmd,
    output logic resume_normal_cmd,
    output logic measure_cmd
);
    // ======================================================================
    // command pulses, one cycle each, idle low
    // ======================================================================
    initial {enter_calibration_cmd, resume_normal_cmd, measure_cmd} = 3'h0;
    // kind 0 enter calibration, 1 resume normal, 2 measure
    task automatic send(input int kind);
        @(posedge sys_clk);
        enter_calibration_cmd <= (kind == 0);
        resume_normal_cmd <= (kind == 1);
        measure_cmd <= (kind == 2);
        @(posedge sys_clk);
        {enter_calibration_cmd, resume_normal_cmd, measure_cmd} <= 3'h0;
    endtask : send
endmodule : sss_master_model

// ==== sensor_startup_sequencer_test.sv ====
// self-checking bench of the startup sequencer
`timescale 1ns/1ps
module sensor_startup_sequencer_test
    import sss_pkg::*;
;
    // ======================================================================
    // stimulus and observed signals
    // ======================================================================
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic swin = 1'h0, slp = 1'h0;
    logic [1:0] rate = 2'h0, proto = 2'h0;
    logic [1:0] cres = 2'h0;
    logic ce = 1'h1, thd = 1'h0;
    logic [TRIM_W-1:0] tt = 3'h5, zt = 3'h2, rt = 3'h7;
    logic ent, res, mea;
    sss_phase_t phase_q;
    logic [1:0] act_q;
    logic [DATA_W-1:0] result_q, temp_q, cap = 14'h2000;
    logic valid_q, thd_q;
    logic [CAP_W-1:0] tcap_q;
    int err_count = 0, checked = 0;
    always #25 sys_clk = ~sys_clk;
    // ======================================================================
    // design and far-side master
    // ======================================================================
    sss_core #(.WIN_SHORT(8), .WIN_LONG(20), .PD1(4), .PD2(6), .PD3(8),
        .CONV8(4), .CONV10(6), .CONV12(8), .CONV14(10)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(ce),
        .enter_calibration_cmd(ent), .resume_normal_cmd(res),
        .measure_cmd(mea), .short_window_cfg(swin), .sleep_mode_cfg(slp),
        .update_rate(rate), .out_proto_cfg(proto),
        .conversion_resolution(cres), .third_order_cfg(thd),
        .temp_trim(tt), .converter_zero_trim(zt),
        .converter_reference_trim(rt),
        .absolute_temperature_voltage(14'h1000), .raw_cap_ratio(cap),
        .sensor_break(14'h3fff), .sensor_coef_lo(16'sh0000),
        .sensor_coef_hi(16'sh0000), .temp_coef(16'sh0000),
        .phase_q(phase_q), .active_proto_q(act_q), .result_q(result_q),
        .result_valid_q(valid_q), .temp_result_q(temp_q),
        .temp_cap_ff_q(tcap_q), .zero_cap_ff_q(), .ref_cap_ff_q(),
        .third_order_q(thd_q));
    sss_master_model i_mst (.sys_clk(sys_clk), .enter_calibration_cmd(ent),
        .resume_normal_cmd(res), .measure_cmd(mea));
    // ======================================================================
    // shared tasks
    // ======================================================================
    task automatic stop_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // compare one settled output value
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    // bounded wait for a phase
    task automatic wait_ph(input sss_phase_t ph);
        int n;
        n = 0;
        while (phase_q !== ph && n < 10000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cmp(16'(phase_q), 16'(ph));
        if (phase_q !== ph)
            stop_test();
    endtask : wait_ph
    // hold reset 10 cycles, check reset state
    task automatic reset_dut(input logic w, input logic s, input logic [1:0] r,
        input logic [1:0] p);
        @(posedge sys_clk);
        {swin, slp, rate, proto, sys_rst} <= {w, s, r, p, 1'h1};
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'h0;
        #1;
        cmp(16'(phase_q), 16'(PH_BOOT));
        cmp(16'(result_q), 16'(RESULT_RST));
        cmp(16'(act_q), 16'(PROTO_I2C));
        @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_WINDOW));
    endtask : reset_dut
    // ======================================================================
    // scenarios
    // ======================================================================
    // short window expires, one cycle, then sleep until measure
    task automatic t_timeout();
        reset_dut(1'h1, 1'h1, RATE_NONE, PROTO_SPI);
        repeat (8) @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_WINDOW));
        @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_WAKE));
        cmp(16'(act_q), 16'(PROTO_SPI));
        cmp(16'(tcap_q), 16'(STEP_FF * 5));
        wait_ph(PH_TCONV);
        wait_ph(PH_CCONV);
        wait_ph(PH_SLEEP);
        cmp(16'(valid_q), 16'h1);
        cmp(16'(result_q), 16'h0080);
        cmp(16'(temp_q), 16'h0040);
        repeat (40) @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_SLEEP));
        i_mst.send(2);
        slp <= 1'h0;
        #1;
        cmp(16'(phase_q), 16'(PH_WAKE));
        wait_ph(PH_CDSP);
        wait_ph(PH_WAKE);
    endtask : t_timeout
    // calibration entry holds, resume starts periodic update
    task automatic t_cmd();
        @(posedge sys_clk);
        {cres, thd} <= {2'h1, 1'h1};
        reset_dut(1'h0, 1'h0, RATE_1, PROTO_PDM);
        i_mst.send(0);
        #1;
        cmp(16'(phase_q), 16'(PH_CMD));
        repeat (40) @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_CMD));
        i_mst.send(1);
        #1;
        cmp(16'(phase_q), 16'(PH_WAKE));
        cmp(16'(act_q), 16'(PROTO_PDM));
        wait_ph(PH_PDOWN);
        cmp(16'(valid_q), 16'h1);
        cmp(16'(result_q), 16'h0200);
        cmp(16'(thd_q), 16'h1);
        @(posedge sys_clk);
        ce <= 1'h0;
        repeat (8) @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_PDOWN));
        @(posedge sys_clk);
        ce <= 1'h1;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp(16'(phase_q), 16'(PH_WAKE));
    endtask : t_cmd
    initial
    begin
        t_timeout();
        t_cmd();
        stop_test();
    end
endmodule : sensor_startup_sequencer_test
